// ===== event_transfer_pkg.sv
// Shared constants for the event transfer controller.
// Assumes a 32-bit memory bus with word-aligned descriptor storage.
package event_transfer_pkg;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_VEC_RD  = 3'b001,
        ST_DESC_RD = 3'b010,
        ST_DATA_RD = 3'b011,
        ST_DATA_WR = 3'b100,
        ST_WB      = 3'b101,
        ST_DONE    = 3'b110
    } state_t;

    // Unit size codes on mem_size_o and in the descriptor
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_WORD = 2'h1;
    localparam logic [1:0] SIZE_LONG = 2'h2;

    // Address stepping codes
    localparam logic [1:0] AM_INC = 2'h2;
    localparam logic [1:0] AM_DEC = 2'h3;

    // Transfer mode codes
    localparam logic [1:0] MD_NORMAL = 2'h0;
    localparam logic [1:0] MD_REPEAT = 2'h1;
    localparam logic [1:0] MD_BLOCK  = 2'h2;

    // Descriptor word 0 field positions
    localparam int SRC_AM_POS   = 30;
    localparam int SIZE_POS     = 28;
    localparam int MODE_POS     = 26;
    localparam int DTS_POS      = 25;
    localparam int CHAIN_EN_POS = 23;
    localparam int CHAIN_SEL_POS = 22;
    localparam int IRQ_SEL_POS  = 21;
    localparam int DST_AM_POS   = 19;

    // Descriptor words: mode, source, destination, counts
    localparam logic [1:0]  DESC_LAST_WORD = 2'h3;
    localparam logic [31:0] DESC_BYTES     = 32'h0000_0010;
    localparam logic [31:0] WORD_BYTES     = 32'h0000_0004;
    localparam logic [8:0]  FULL_BLOCK     = 9'h100;

    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [15:0] RST_HALF = 16'h0000;

endpackage : event_transfer_pkg

// ===== arb_if.sv
// Carrier between the controller and its source arbiter.
// Assumes both ends run on the same system clock.
`timescale 1ns/10ps
`default_nettype none
interface arb_if #(parameter int NUM_SRC = 26);
    logic [NUM_SRC-1:0]         act_req;
    logic [NUM_SRC-1:0]         act_en;
    logic                       grant_vld;
    logic [$clog2(NUM_SRC)-1:0] grant_idx;

    modport ctrl (output act_req, output act_en,
                  input grant_vld, input grant_idx);
    modport arb  (input act_req, input act_en,
                  output grant_vld, output grant_idx);
endinterface : arb_if
`default_nettype wire

// ===== event_src_arbiter.sv
// Fixed-priority selection of the pending activation source.
// Assumes index 0 is the highest priority source.
`timescale 1ns/10ps
`default_nettype none
module event_src_arbiter #(
    parameter int NUM_SRC = 26
) (
    arb_if.arb bus
);
    logic [NUM_SRC-1:0] pend;
    logic [NUM_SRC:0]   above;
    logic [NUM_SRC-1:0] onehot;

    assign above[0] = 1'b0;

    generate
        for (genvar g = 0; g < NUM_SRC; g++) begin : g_src
            assign pend[g]     = bus.act_req[g] & bus.act_en[g];
            assign onehot[g]   = pend[g] & ~above[g];
            assign above[g+1]  = above[g] | pend[g];
        end
    endgenerate

    always_comb begin
        bus.grant_idx = '0;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (onehot[i]) begin
                bus.grant_idx = i[$clog2(NUM_SRC)-1:0];
            end
        end
    end

    assign bus.grant_vld = above[NUM_SRC];

endmodule : event_src_arbiter
`default_nettype wire

// ===== event_transfer_ctrl.sv
// Event-activated transfer controller: descriptor fetch, move, writeback.
// Assumes a memory slave that holds ack high for one cycle per access.
`timescale 1ns/10ps
`default_nettype none
module event_transfer_ctrl
    import event_transfer_pkg::*;
#(
    parameter int NUM_SRC = 26
) (
    input  wire logic               clk_sys_i,
    input  wire logic               rst_b_i,
    input  wire logic [NUM_SRC-1:0] act_req_i,
    input  wire logic [NUM_SRC-1:0] source_activation_enable_i,
    input  wire logic [31:0]        vector_base_i,
    output logic                    mem_req_o,
    output logic                    mem_we_o,
    output logic [1:0]              mem_size_o,
    output logic [31:0]             mem_addr_o,
    output logic [31:0]             mem_wdata_o,
    input  wire logic [31:0]        mem_rdata_i,
    input  wire logic               mem_ack_i,
    output logic                    cpu_irq_o,
    output logic [NUM_SRC-1:0]      clear_flag_o,
    output logic [NUM_SRC-1:0]      clear_enable_o,
    output logic                    busy_o
);
    localparam int IW = $clog2(NUM_SRC);

    if (NUM_SRC < 2 || NUM_SRC > 64) begin : g_bad_num_src
        $error("NUM_SRC out of range");
    end

    logic [1:0] rst_sync_ff;
    logic       rst_b;

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_sync_ff <= 2'b00;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_b = rst_sync_ff[1];

    arb_if #(.NUM_SRC(NUM_SRC)) arb ();
    assign arb.act_req = act_req_i;
    assign arb.act_en  = source_activation_enable_i;

    event_src_arbiter #(.NUM_SRC(NUM_SRC)) u_arb (
        .bus (arb)
    );

    state_t             state_ff,    nxt_state;
    logic [IW-1:0]      idx_ff,      nxt_idx;
    logic [1:0]         word_ff,     nxt_word;
    logic [31:0]        desc_ff,     nxt_desc;
    logic [15:0]        mode_ff,     nxt_mode;
    logic [31:0]        src_ff,      nxt_src;
    logic [31:0]        dst_ff,      nxt_dst;
    logic [15:0]        cnt_a_ff,    nxt_cnt_a;
    logic [15:0]        cnt_b_ff,    nxt_cnt_b;
    logic               req_ff,      nxt_req;
    logic               we_ff,       nxt_we;
    logic [1:0]         size_ff,     nxt_size;
    logic [31:0]        addr_ff,     nxt_addr;
    logic [31:0]        wdata_ff,    nxt_wdata;
    logic               irq_ff,      nxt_irq;
    logic [NUM_SRC-1:0] clr_flag_ff, nxt_clr_flag;
    logic [NUM_SRC-1:0] clr_en_ff,   nxt_clr_en;

    // Descriptor mode fields
    logic [1:0] src_am, dst_am, usize, tmode;
    logic       dts, chain_en, chain_sel, irq_sel;
    assign src_am    = mode_ff[SRC_AM_POS-16 +: 2];
    assign usize     = mode_ff[SIZE_POS-16 +: 2];
    assign tmode     = mode_ff[MODE_POS-16 +: 2];
    assign dts       = mode_ff[DTS_POS-16];
    assign chain_en  = mode_ff[CHAIN_EN_POS-16];
    assign chain_sel = mode_ff[CHAIN_SEL_POS-16];
    assign irq_sel   = mode_ff[IRQ_SEL_POS-16];
    assign dst_am    = mode_ff[DST_AM_POS-16 +: 2];

    function automatic logic [31:0] step_addr(input logic [31:0] a,
                                              input logic [1:0]  am,
                                              input logic [1:0]  sz);
        logic [31:0] unit;
        unit = 32'h0000_0001 << sz;
        case (am)
            AM_INC:  step_addr = a + unit;
            AM_DEC:  step_addr = a - unit;
            default: step_addr = a;
        endcase
    endfunction : step_addr

    // Undo a full pass of reload units, back to the area's start
    function automatic logic [31:0] restore(input logic [31:0] a,
                                            input logic [1:0]  am,
                                            input logic [1:0]  sz,
                                            input logic [7:0]  hi);
        logic [8:0]  units;
        logic [31:0] span;
        units = (hi == 8'h00) ? FULL_BLOCK : {1'b0, hi};
        span  = {23'h000000, units} << sz;
        case (am)
            AM_INC:  restore = a - span;
            AM_DEC:  restore = a + span;
            default: restore = a;
        endcase
    endfunction : restore

    logic [31:0] src_step, dst_step;
    logic [7:0]  lo_dec;
    logic        test_zero;
    logic [31:0] wb_word;
    logic [1:0]  wb_next;

    assign src_step = step_addr(src_ff, src_am, usize);
    assign dst_step = step_addr(dst_ff, dst_am, usize);
    assign lo_dec   = cnt_a_ff[7:0] - 8'h01;

    always_comb begin
        case (tmode)
            MD_REPEAT: test_zero = (cnt_a_ff[7:0] == 8'h00);
            MD_BLOCK:  test_zero = (cnt_b_ff == RST_HALF);
            default:   test_zero = (cnt_a_ff == RST_HALF);
        endcase
    end

    // Word that follows the one now being written back
    assign wb_next = word_ff + 2'h1;

    always_comb begin
        case (wb_next)
            2'h0:    wb_word = {mode_ff, RST_HALF};
            2'h1:    wb_word = src_ff;
            2'h2:    wb_word = dst_ff;
            default: wb_word = {cnt_a_ff, cnt_b_ff};
        endcase
    end

    always_comb begin
        nxt_state    = state_ff;
        nxt_idx      = idx_ff;
        nxt_word     = word_ff;
        nxt_desc     = desc_ff;
        nxt_mode     = mode_ff;
        nxt_src      = src_ff;
        nxt_dst      = dst_ff;
        nxt_cnt_a    = cnt_a_ff;
        nxt_cnt_b    = cnt_b_ff;
        nxt_req      = req_ff;
        nxt_we       = we_ff;
        nxt_size     = size_ff;
        nxt_addr     = addr_ff;
        nxt_wdata    = wdata_ff;
        nxt_irq      = 1'b0;
        nxt_clr_flag = '0;
        nxt_clr_en   = '0;
        case (state_ff)
            ST_IDLE: begin
                if (arb.grant_vld) begin
                    nxt_idx   = arb.grant_idx;
                    nxt_addr  = vector_base_i
                              + {{(30-IW){1'b0}}, arb.grant_idx, 2'b00};
                    nxt_req   = 1'b1;
                    nxt_we    = 1'b0;
                    nxt_size  = SIZE_LONG;
                    nxt_state = ST_VEC_RD;
                end
            end
            ST_VEC_RD: begin
                if (mem_ack_i) begin
                    // Low two bits ignored: descriptors are word aligned
                    nxt_desc  = {mem_rdata_i[31:2], 2'b00};
                    nxt_addr  = {mem_rdata_i[31:2], 2'b00};
                    nxt_word  = 2'h0;
                    nxt_state = ST_DESC_RD;
                end
            end
            ST_DESC_RD: begin
                if (mem_ack_i) begin
                    case (word_ff)
                        2'h0:    nxt_mode = mem_rdata_i[31:16];
                        2'h1:    nxt_src  = mem_rdata_i;
                        2'h2:    nxt_dst  = mem_rdata_i;
                        default: begin
                            nxt_cnt_a = mem_rdata_i[31:16];
                            nxt_cnt_b = mem_rdata_i[15:0];
                        end
                    endcase
                    if (word_ff == DESC_LAST_WORD) begin
                        nxt_addr  = src_ff;
                        nxt_size  = usize;
                        nxt_state = ST_DATA_RD;
                    end else begin
                        nxt_word = word_ff + 2'h1;
                        nxt_addr = addr_ff + WORD_BYTES;
                    end
                end
            end
            ST_DATA_RD: begin
                if (mem_ack_i) begin
                    nxt_we    = 1'b1;
                    nxt_addr  = dst_ff;
                    nxt_wdata = mem_rdata_i;
                    nxt_state = ST_DATA_WR;
                end
            end
            ST_DATA_WR: begin
                if (mem_ack_i) begin
                    nxt_src   = src_step;
                    nxt_dst   = dst_step;
                    nxt_we    = 1'b1;
                    nxt_size  = SIZE_LONG;
                    nxt_addr  = desc_ff;
                    nxt_word  = 2'h0;
                    nxt_wdata = {mode_ff, RST_HALF};
                    nxt_state = ST_WB;
                    case (tmode)
                        MD_REPEAT: begin
                            if (cnt_a_ff[7:0] == 8'h01) begin
                                nxt_cnt_a[7:0] = cnt_a_ff[15:8];
                                if (dts) begin
                                    nxt_src = restore(src_step, src_am,
                                                      usize, cnt_a_ff[15:8]);
                                end else begin
                                    nxt_dst = restore(dst_step, dst_am,
                                                      usize, cnt_a_ff[15:8]);
                                end
                            end else begin
                                nxt_cnt_a[7:0] = lo_dec;
                            end
                        end
                        MD_BLOCK: begin
                            nxt_cnt_a[7:0] = lo_dec;
                            if (lo_dec == 8'h00) begin
                                nxt_cnt_a[7:0] = cnt_a_ff[15:8];
                                nxt_cnt_b      = cnt_b_ff - 16'h0001;
                                if (dts) begin
                                    nxt_src = restore(src_step, src_am,
                                                      usize, cnt_a_ff[15:8]);
                                end else begin
                                    nxt_dst = restore(dst_step, dst_am,
                                                      usize, cnt_a_ff[15:8]);
                                end
                            end else begin
                                // Whole block moves within one request
                                nxt_we    = 1'b0;
                                nxt_size  = usize;
                                nxt_addr  = src_step;
                                nxt_state = ST_DATA_RD;
                            end
                        end
                        default: nxt_cnt_a = cnt_a_ff - 16'h0001;
                    endcase
                end
            end
            ST_WB: begin
                if (mem_ack_i) begin
                    nxt_word  = wb_next;
                    nxt_addr  = addr_ff + WORD_BYTES;
                    nxt_wdata = wb_word;
                    if (word_ff == DESC_LAST_WORD) begin
                        if (chain_en && (!chain_sel || test_zero)) begin
                            nxt_desc  = desc_ff + DESC_BYTES;
                            nxt_addr  = desc_ff + DESC_BYTES;
                            nxt_we    = 1'b0;
                            nxt_word  = 2'h0;
                            nxt_state = ST_DESC_RD;
                        end else begin
                            nxt_req   = 1'b0;
                            nxt_we    = 1'b0;
                            nxt_state = ST_DONE;
                            if (irq_sel) begin
                                nxt_irq    = 1'b1;
                                // CPU takes the request: hand the source back
                                nxt_clr_en = NUM_SRC'(1) << idx_ff;
                            end else begin
                                nxt_clr_flag = NUM_SRC'(1) << idx_ff;
                            end
                        end
                    end
                end
            end
            ST_DONE: begin
                // One idle cycle lets the cleared flag fall before re-arbitration
                nxt_state = ST_IDLE;
            end
            default: nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rst_b) begin
        if (!rst_b) begin
            state_ff    <= ST_IDLE;
            idx_ff      <= '0;
            word_ff     <= 2'h0;
            desc_ff     <= RST_WORD;
            mode_ff     <= RST_HALF;
            src_ff      <= RST_WORD;
            dst_ff      <= RST_WORD;
            cnt_a_ff    <= RST_HALF;
            cnt_b_ff    <= RST_HALF;
            req_ff      <= 1'b0;
            we_ff       <= 1'b0;
            size_ff     <= SIZE_LONG;
            addr_ff     <= RST_WORD;
            wdata_ff    <= RST_WORD;
            irq_ff      <= 1'b0;
            clr_flag_ff <= '0;
            clr_en_ff   <= '0;
        end else begin
            state_ff    <= nxt_state;
            idx_ff      <= nxt_idx;
            word_ff     <= nxt_word;
            desc_ff     <= nxt_desc;
            mode_ff     <= nxt_mode;
            src_ff      <= nxt_src;
            dst_ff      <= nxt_dst;
            cnt_a_ff    <= nxt_cnt_a;
            cnt_b_ff    <= nxt_cnt_b;
            req_ff      <= nxt_req;
            we_ff       <= nxt_we;
            size_ff     <= nxt_size;
            addr_ff     <= nxt_addr;
            wdata_ff    <= nxt_wdata;
            irq_ff      <= nxt_irq;
            clr_flag_ff <= nxt_clr_flag;
            clr_en_ff   <= nxt_clr_en;
        end
    end

    // Lane placement of narrow units is left to the memory slave
    assign mem_req_o      = req_ff;
    assign mem_we_o       = we_ff;
    assign mem_size_o     = size_ff;
    assign mem_addr_o     = addr_ff;
    assign mem_wdata_o    = wdata_ff;
    assign cpu_irq_o      = irq_ff;
    assign clear_flag_o   = clr_flag_ff;
    assign clear_enable_o = clr_en_ff;
    assign busy_o         = (state_ff != ST_IDLE);

endmodule : event_transfer_ctrl
`default_nettype wire

// ===== event_transfer_ctrl_assertions.sv
// Port-level checker for the event transfer controller.
// Assumes one clock domain and the active-low reset seen at the pins.
`timescale 1ns/10ps
`default_nettype none
module event_transfer_ctrl_assertions
    import event_transfer_pkg::*;
#(
    parameter int NUM_SRC = 26
) (
    input wire logic               clk_sys_i,
    input wire logic               rst_b_i,
    input wire logic [NUM_SRC-1:0] act_req_i,
    input wire logic [NUM_SRC-1:0] source_activation_enable_i,
    input wire logic [31:0]        vector_base_i,
    input wire logic               mem_req_o,
    input wire logic               mem_we_o,
    input wire logic [1:0]         mem_size_o,
    input wire logic [31:0]        mem_addr_o,
    input wire logic               mem_ack_i,
    input wire logic               cpu_irq_o,
    input wire logic [NUM_SRC-1:0] clear_flag_o,
    input wire logic [NUM_SRC-1:0] clear_enable_o,
    input wire logic               busy_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);

    logic [NUM_SRC-1:0] clr;
    logic [NUM_SRC-1:0] pend;
    logic [31:0]        voff;
    assign clr  = clear_flag_o | clear_enable_o;
    assign pend = act_req_i & source_activation_enable_i;
    assign voff = mem_addr_o - vector_base_i;

    req_stand_a: assert property (mem_req_o && !mem_ack_i |=> mem_req_o
        && $stable(mem_addr_o) && $stable(mem_we_o) && $stable(mem_size_o))
        else $error("access changed before ack");
    vec_first_a: assert property ($rose(mem_req_o) |-> !mem_we_o
        && mem_size_o == SIZE_LONG && voff[1:0] == 2'h0
        && voff < 32'(4 * NUM_SRC))
        else $error("activation did not start with a vector read");
    irq_pulse_a: assert property (cpu_irq_o |=> !cpu_irq_o)
        else $error("cpu interrupt longer than one cycle");
    irq_clear_a: assert property (cpu_irq_o |-> $onehot(clear_enable_o)
        && clear_flag_o == '0)
        else $error("interrupt without enable clear");
    flag_only_a: assert property (|clear_flag_o |-> !cpu_irq_o
        && $onehot(clear_flag_o) && clear_enable_o == '0)
        else $error("flag clear came with an interrupt");
    // Source may drop its request in the clear cycle: look one cycle back
    clear_src_a: assert property (|clr |->
        (clr & ~$past(pend)) == '0)
        else $error("cleared a source that was not active");
    end_quiet_a: assert property (|clr |-> !mem_req_o ##1
        (!mem_req_o && clr == '0))
        else $error("bus or clear active after the end");
    idle_quiet_a: assert property (!busy_o |-> !mem_req_o && !cpu_irq_o)
        else $error("activity while idle");
endmodule : event_transfer_ctrl_assertions

bind event_transfer_ctrl event_transfer_ctrl_assertions #(.NUM_SRC(NUM_SRC))
    event_transfer_ctrl_assertions_i (
    .clk_sys_i                  (clk_sys_i),
    .rst_b_i                    (rst_b_i),
    .act_req_i                  (act_req_i),
    .source_activation_enable_i (source_activation_enable_i),
    .vector_base_i              (vector_base_i),
    .mem_req_o                  (mem_req_o),
    .mem_we_o                   (mem_we_o),
    .mem_size_o                 (mem_size_o),
    .mem_addr_o                 (mem_addr_o),
    .mem_ack_i                  (mem_ack_i),
    .cpu_irq_o                  (cpu_irq_o),
    .clear_flag_o               (clear_flag_o),
    .clear_enable_o             (clear_enable_o),
    .busy_o                     (busy_o)
);
`default_nettype wire

// ===== mem_model.sv
// Behavioural memory slave with a settable wait count.
// Assumes word-aligned storage of 256 words, addresses below 1 KiB.
`timescale 1ns/10ps
`default_nettype none
module mem_model (
    input  wire logic        clk_sys_i,
    input  wire logic        rst_b_i,
    input  wire logic        req_i,
    input  wire logic        we_i,
    input  wire logic [31:0] addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic [3:0]  wait_i,
    output logic [31:0]      rdata_o,
    output logic             ack_o
);
    logic [31:0] mem [0:255];
    logic [3:0]  cnt_ff;

    always @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ack_o   <= 1'b0;
            cnt_ff  <= 4'h0;
            rdata_o <= 32'h0000_0000;
        end else if (req_i && !ack_o && cnt_ff == wait_i) begin
            ack_o   <= 1'b1;
            cnt_ff  <= 4'h0;
            rdata_o <= mem[addr_i[9:2]];
            if (we_i) begin
                mem[addr_i[9:2]] <= wdata_i;
            end
        end else begin
            ack_o   <= 1'b0;
            // Released data toggles so stale values never look valid
            rdata_o <= ~rdata_o;
            if (req_i && !ack_o) begin
                cnt_ff <= cnt_ff + 4'h1;
            end
        end
    end
endmodule : mem_model
`default_nettype wire

// ===== event_transfer_ctrl_test.sv
// Self-checking bench: descriptors in the memory model, one run per case except the final disabled-source check.
// Assumes the checker is bound in through its own file.
`timescale 1ns/10ps
`default_nettype none
module event_transfer_ctrl_test
    import event_transfer_pkg::*;
;
    logic        clk_sys_i = 1'b0;
    logic        rst_b_i   = 1'b0;
    logic [25:0] act_req, act_en, clr_f, clr_e;
    logic [31:0] vbase, addr, wdata, rdata;
    logic        req, we, ack, irq, busy;
    logic [1:0]  sz;
    logic [3:0]  wt;
    logic [31:0] log_a [0:31];
    logic        log_w [0:31];
    int          bad_count, n_tests, n_acc, n_irq, n_flag, n_en, cyc;

    event_transfer_ctrl #(.NUM_SRC(26)) event_transfer_ctrl_i (
        .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .act_req_i(act_req),
        .source_activation_enable_i(act_en), .vector_base_i(vbase),
        .mem_req_o(req), .mem_we_o(we), .mem_size_o(sz), .mem_addr_o(addr),
        .mem_wdata_o(wdata), .mem_rdata_i(rdata), .mem_ack_i(ack),
        .cpu_irq_o(irq), .clear_flag_o(clr_f), .clear_enable_o(clr_e),
        .busy_o(busy));
    mem_model mem_model_i (
        .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .req_i(req), .we_i(we),
        .addr_i(addr), .wdata_i(wdata), .wait_i(wt), .rdata_o(rdata),
        .ack_o(ack));

    always #2.5 clk_sys_i = ~clk_sys_i;

    always @(posedge clk_sys_i) begin
        cyc++;
        if (req && ack && n_acc < 32) begin
            log_a[n_acc] = addr;
            log_w[n_acc] = we;
            n_acc++;
        end
        n_irq  += int'(irq);
        n_flag += int'(|clr_f);
        n_en   += int'(|clr_e);
        if (cyc == 3000) begin
            bad_count++;
            test_done();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic acc(input int k, input logic [31:0] a, input logic w);
        chk(log_a[k], a);
        chk({31'h0, log_w[k]}, {31'h0, w});
    endtask : acc

    task automatic ends(input int i, input int f, input int e);
        chk(32'(n_irq), 32'(i));
        chk(32'(n_flag), 32'(f));
        chk(32'(n_en), 32'(e));
    endtask : ends

    function automatic logic [31:0] mw(input logic [1:0] sa, input logic [1:0] s,
        input logic [1:0] md, input logic ds, input logic ce, input logic cs,
        input logic ir, input logic [1:0] da);
        return {sa, s, md, ds, 1'b0, ce, cs, ir, da, 19'h0};
    endfunction : mw

    task automatic desc(input logic [31:0] v, input logic [31:0] d,
        input logic [31:0] w0, input logic [31:0] s, input logic [31:0] dd,
        input logic [31:0] c);
        mem_model_i.mem[v[9:2]]        = d;
        mem_model_i.mem[d[9:2]]        = w0;
        mem_model_i.mem[d[9:2] + 8'h1] = s;
        mem_model_i.mem[d[9:2] + 8'h2] = dd;
        mem_model_i.mem[d[9:2] + 8'h3] = c;
    endtask : desc

    // Source drops its flag at the first clear pulse, and its enable too on an enable clear
    task automatic run(input int s, input logic [3:0] w);
        int t;
        wt     = w;
        n_acc  = 0;
        n_irq  = 0;
        n_flag = 0;
        n_en   = 0;
        act_req[s] = 1'b1;
        for (t = 0; t < 400 && !(|clr_f || |clr_e); t++) @(negedge clk_sys_i);
        if (|clr_e) act_en[s] = 1'b0;
        act_req[s] = 1'b0;
        for (t = 0; t < 20 && busy; t++) @(negedge clk_sys_i);
        @(negedge clk_sys_i);
    endtask : run

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : test_done

    initial begin
        act_req = '0;
        act_en  = '0;
        vbase   = 32'h0000_0040;
        wt      = 4'h0;
        repeat (4) @(negedge clk_sys_i);
        rst_b_i = 1'b1;
        repeat (3) @(negedge clk_sys_i);
        act_en = 26'h000002B;
        desc(32'h4C, 32'h100, mw(AM_INC, SIZE_LONG, MD_NORMAL, 1'b0, 1'b0,
             1'b0, 1'b0, AM_DEC), 32'h200, 32'h300, 32'h0005_0000);
        mem_model_i.mem[8'h80] = 32'hA5A5_1234;
        run(3, 4'h0);
        chk(32'(n_acc), 32'd11);
        acc(0, 32'h4C, 1'b0);
        for (int k = 0; k < 4; k++) begin
            acc(1 + k, 32'h100 + 32'(4 * k), 1'b0);
            acc(7 + k, 32'h100 + 32'(4 * k), 1'b1);
        end
        acc(5, 32'h200, 1'b0);
        acc(6, 32'h300, 1'b1);
        chk(mem_model_i.mem[8'hC0], 32'hA5A5_1234);
        chk(mem_model_i.mem[8'h41], 32'h204);
        chk(mem_model_i.mem[8'h42], 32'h2FC);
        chk(mem_model_i.mem[8'h43], 32'h0004_0000);
        ends(0, 1, 0);
        desc(32'h40, 32'h120, mw(AM_INC, SIZE_LONG, MD_REPEAT, 1'b1, 1'b0,
             1'b0, 1'b1, AM_INC), 32'h208, 32'h310, 32'h0301_0000);
        mem_model_i.mem[8'h82] = 32'h5A5A_0001;
        run(0, 4'h2);
        chk(mem_model_i.mem[8'hC4], 32'h5A5A_0001);
        chk(mem_model_i.mem[8'h49], 32'h200);
        chk(mem_model_i.mem[8'h4A], 32'h314);
        chk(mem_model_i.mem[8'h4B], 32'h0303_0000);
        ends(1, 0, 1);
        desc(32'h54, 32'h140, mw(2'h0, SIZE_LONG, MD_NORMAL, 1'b0, 1'b1,
             1'b1, 1'b0, 2'h0), 32'h220, 32'h320, 32'h0001_0000);
        desc(32'h00, 32'h150, mw(AM_INC, SIZE_LONG, MD_NORMAL, 1'b0, 1'b0,
             1'b0, 1'b0, AM_INC), 32'h224, 32'h324, 32'h0002_0000);
        run(5, 4'h1);
        chk(32'(n_acc), 32'd21);
        acc(11, 32'h150, 1'b0);
        acc(15, 32'h224, 1'b0);
        acc(20, 32'h15C, 1'b1);
        chk(mem_model_i.mem[8'h51], 32'h220);
        chk(mem_model_i.mem[8'h57], 32'h0001_0000);
        ends(0, 1, 0);
        mem_model_i.mem[8'h53] = 32'h0005_0000;
        run(5, 4'h3);
        chk(32'(n_acc), 32'd11);
        ends(0, 1, 0);
        desc(32'h44, 32'h180, mw(AM_INC, SIZE_WORD, MD_BLOCK, 1'b0, 1'b0,
             1'b0, 1'b1, AM_INC), 32'h240, 32'h340, 32'h0202_0002);
        run(1, 4'h0);
        chk(32'(n_acc), 32'd13);
        acc(7, 32'h242, 1'b0);
        acc(8, 32'h342, 1'b1);
        chk(mem_model_i.mem[8'h61], 32'h244);
        chk(mem_model_i.mem[8'h62], 32'h340);
        chk(mem_model_i.mem[8'h63], 32'h0202_0001);
        ends(1, 0, 1);
        act_req[7] = 1'b1;
        repeat (20) @(negedge clk_sys_i);
        chk({31'h0, busy}, 32'h0);
        act_req[7] = 1'b0;
        test_done();
    end
endmodule : event_transfer_ctrl_test
`default_nettype wire
